// [dv/sadc_host_model.sv]
// sadc_host_model: host side of the converter; strobe, shift clock, pin
// assumes: tasks are called from the bench one at a time
`timescale 1ns/10ps
`default_nettype none

module sadc_host_model (
  input wire logic i_clock,
  input wire logic i_busy,
  input wire logic i_powered_up,
  input wire logic i_sdo,
  output logic o_convert_strobe,
  output logic o_sck,
  output logic o_enable_or_serial_in
);
  // shift clock stands still between frames
  initial
  begin
    o_convert_strobe = 1'b0;
    o_sck = 1'b0;
    o_enable_or_serial_in = 1'b1;
  end

  task automatic set_pin(input logic v);
    @(posedge i_clock);
    o_enable_or_serial_in <= v;
  endtask

  // gap of 8 cycles keeps starts over 1 us apart with the readout
  task automatic convert(output int rise, output int width);
    rise = 0;
    width = 0;
    repeat (8) @(posedge i_clock);
    o_convert_strobe <= 1'b1;
    do
    begin
      @(posedge i_clock);
      #1;
      rise++;
    end while (i_busy !== 1'b1 && rise < 10);
    while (i_busy === 1'b1 && width < 40)
    begin
      if (i_powered_up === 1'b1)
        width++;
      @(posedge i_clock);
      #1;
    end
    @(posedge i_clock);
    o_convert_strobe <= 1'b0;
  endtask

  // frames start only after busy fell, far past the quiet time
  // sample before each rise; serial-in moves half a period ahead of it
  task automatic shift(input int n, input logic [31:0] up,
                       output logic [31:0] got);
    got = '0;
    #7;
    for (int k = n - 1; k >= 0; k--)
    begin
      got[k] = i_sdo;
      o_enable_or_serial_in = up[k];
      #16 o_sck = 1'b1;
      #16 o_sck = 1'b0;
    end
  endtask
endmodule // sadc_host_model

`default_nettype wire

// [dv/tb_top.sv]
// tb_top: self-checking bench for the converter block
// assumes: sadc_top design files and sadc_host_model compiled before it
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import sadc_pkg::*;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic chain_sel = 1'b0;
  sadc_word_t s_data = 16'h0000;
  logic s_valid = 1'b0;
  logic conv, sck, pin, ready, busy, powered, sdo, sdo_oe;
  int fail_count = 0;
  int n_checks = 0;

  always #10 i_clock = ~i_clock;

  sadc_top i_dut (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_convert_strobe(conv), .i_chain_select(chain_sel),
    .i_enable_or_serial_in(pin), .i_sck(sck), .i_sample_data(s_data),
    .i_sample_valid(s_valid), .o_sample_ready(ready), .o_busy(busy),
    .o_powered_up(powered), .o_sdo(sdo), .o_sdo_oe(sdo_oe));

  sadc_host_model i_host (.i_clock(i_clock), .i_busy(busy),
    .i_powered_up(powered), .i_sdo(sdo), .o_convert_strobe(conv),
    .o_sck(sck), .o_enable_or_serial_in(pin));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one conversion and a frame of n bits; checks start delay and width
  task automatic conv_read(input int n, input logic [31:0] up,
                           input logic [31:0] exp);
    int rise;
    int width;
    logic [31:0] got;
    i_host.convert(rise, width);
    chk("busy delay ok", 1, 32'(rise inside {3, 4}));
    chk("busy width", 23, width);
    i_host.shift(n, up, got);
    chk("frame", exp, got);
  endtask

  task automatic t_reset();
    @(posedge i_clock);
    #1;
    chk("busy", 0, busy);
    chk("oe", 0, sdo_oe);
    chk("ready", 1, ready);
    chk("powered", 0, powered);
    chk("sdo", 0, sdo);
    $display("test reset done");
  endtask

  // pin high releases the output, low drives it
  task automatic t_enable();
    for (int v = 1; v >= 0; v--)
    begin
      i_host.set_pin(v[0]);
      repeat (4) @(posedge i_clock);
      #1;
      chk("oe", !v[0], sdo_oe);
    end
    $display("test enable done");
  endtask

  // fill until refused, then drain by conversions, oldest first
  task automatic t_fifo();
    int n;
    sadc_word_t w;
    n = 0;
    @(posedge i_clock);
    s_valid <= 1'b1;
    s_data <= 16'h7fff;
    repeat (36)
    begin
      @(negedge i_clock);
      if (ready === 1'b1)
        n++;
      @(posedge i_clock);
      s_data <= 16'h7fff + 16'(n * 16'h0803);
    end
    s_valid <= 1'b0;
    chk("words taken", 32, n);
    chk("ready full", 0, ready);
    for (int i = 0; i < 32; i++)
    begin
      w = 16'h7fff + 16'(i * 16'h0803);
      // normal mode pads with zeros after bit 0
      conv_read(20, 0, {12'h000, w ^ 16'h8000, 4'h0});
      if (i == 0)
        chk("ready freed", 1, ready);
    end
    conv_read(16, 0, 32'h0000_0000);
    $display("test fifo done");
  endtask

  // chain mode: result first, then the upstream word
  task automatic t_chain();
    logic [31:0] got;
    @(posedge i_clock);
    chain_sel <= 1'b1;
    s_valid <= 1'b1;
    s_data <= 16'h1234;
    @(posedge i_clock);
    s_valid <= 1'b0;
    // a few edges let the mode reach the link side before the frame
    i_host.shift(4, 0, got);
    conv_read(32, 32'ha5c3_0000, 32'h9234_a5c3);
    // pin high would release the output in normal mode, not in chain mode
    i_host.set_pin(1'b1);
    repeat (4) @(posedge i_clock);
    #1;
    chk("oe chain", 1, sdo_oe);
    @(posedge i_clock);
    chain_sel <= 1'b0;
    repeat (4) @(posedge i_clock);
    #1;
    chk("oe normal", 0, sdo_oe);
    $display("test chain done");
  endtask

  initial
  begin
    repeat (2) @(posedge i_clock);
    i_arst_n <= 1'b1;
    t_reset();
    t_enable();
    t_fifo();
    t_chain();
    wrap_up();
  end

  // tests need about 2400 cycles; 20000 means a hang
  initial
  begin
    #400000;
    fail_count++;
    $display("Error watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule // tb_top

`default_nettype wire

// [hdl/sadc_cfg.svh]
// sadc_cfg.svh: offsets, codes and timing counts of the converter block
// assumes: included by its bare name; definitions only
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// result word
`define SADC_WORD_W 16
`define SADC_MSB 15
`define SADC_SIGN_FLIP 16'h8000
`define SADC_MID_CODE 16'h8000

// sample buffer
`define SADC_FIFO_DEPTH 32
`define SADC_FIFO_AW 5

// system clock and conversion time
`define SADC_CLK_PERIOD_NS 20
`define SADC_TCONV_MIN_NS 460
`define SADC_TCONV_MAX_NS 527
`define SADC_CONV_CYC_MIN \
  ((`SADC_TCONV_MIN_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)
`define SADC_CONV_CYC_MAX (`SADC_TCONV_MAX_NS / `SADC_CLK_PERIOD_NS)
`define SADC_CNT_W 5

// pin synchroniser reset: the shared enable pin idles high (released)
`define SADC_PIN_IDLE 3'h4

`endif

// [hdl/sadc_fifo.sv]
// sadc_fifo: synchronous sample buffer with registered full and empty
// assumes: one clock; a word moves when valid and ready are both high
`timescale 1ns/10ps
`default_nettype none
`include "sadc_cfg.svh"

module sadc_fifo #(
  parameter int WIDTH = `SADC_WORD_W,
  parameter int DEPTH = `SADC_FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  sadc_stream_if.snk s_in,
  sadc_stream_if.src s_out
);
  import sadc_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic full_reg, full_next, empty_reg, empty_next;
  logic push, pop;
  logic [AW:0] fill;

  // flags are registered so the filling side sees a clean ready
  always_comb
  begin
    push = s_in.valid && !full_reg;
    pop = s_out.ready && !empty_reg;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    fill = wr_ptr_next - rd_ptr_next;
    full_next = (fill == (AW+1)'(DEPTH));
    empty_next = (fill == '0);
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      full_reg <= full_next;
      empty_reg <= empty_next;
    end
  end

  // storage has no reset; empty guards every read
  always_ff @(posedge i_clock)
  begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= s_in.data;
  end

  assign s_in.ready = !full_reg;
  assign s_out.valid = !empty_reg;
  assign s_out.data = mem[rd_ptr_reg[AW-1:0]];
endmodule // sadc_fifo

`default_nettype wire

// [hdl/sadc_pkg.sv]
// sadc_pkg: types shared by the converter block
// assumes: sadc_cfg.svh sits beside it on the include path
`default_nettype none
`include "sadc_cfg.svh"

package sadc_pkg;
  typedef logic [`SADC_WORD_W-1:0] sadc_word_t;
  typedef logic [`SADC_CNT_W-1:0] sadc_cnt_t;
  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_CONV = 2'b01
  } sadc_state_t;
endpackage

`default_nettype wire

// [hdl/sadc_stream_if.sv]
// sadc_stream_if: valid/ready word stream between the block's modules
// assumes: both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none

interface sadc_stream_if;
  sadc_pkg::sadc_word_t data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

// [hdl/sadc_top.sv]
// sadc_top: conversion control and serial readout of a 16-bit converter
// assumes: i_clock at 50 MHz; i_sck is the host's shift clock, which
// stays quiet while busy is high and may stop between readouts
//
// Summary of operation
// R1 - strobe rising edge wakes core, starts conversion
// R2 - busy high for 460 to 527 ns
// R3 - host keeps strobe widths, 1 us spacing
// R4 - host keeps shift clock quiet after start
// R5 - mode low: shared pin enables serial output
// R6 - mode high: shared pin is chain input
// R7 - enable low drives output, high releases it
// R8 - one bit per shift edge, MSB first
// R9 - results coded in two's complement
// R10 - first bit ready as busy falls
// R11 - chain input sampled, shifted after result
// R12 - host keeps 10 / 13.5 ns clock periods
// R13 - host captures output on rising edge
// R14 - fresh 16-bit word at conversion end
// R15 - chain mode acts as 16-bit shift register
`timescale 1ns/10ps
`default_nettype none
`include "sadc_cfg.svh"

module sadc_top (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_convert_strobe,
  input wire logic i_chain_select,
  input wire logic i_enable_or_serial_in,
  input wire logic i_sck,
  input wire sadc_pkg::sadc_word_t i_sample_data,
  input wire logic i_sample_valid,
  output logic o_sample_ready,
  output logic o_busy,
  output logic o_powered_up,
  output logic o_sdo,
  output logic o_sdo_oe
);
  import sadc_pkg::*;

  localparam int ConvMin = `SADC_CONV_CYC_MIN;
  localparam int ConvMax = `SADC_CONV_CYC_MAX;
  localparam int ConvHold = `SADC_CONV_CYC_MIN - 1;
  localparam sadc_cnt_t ConvLast = sadc_cnt_t'(`SADC_CONV_CYC_MIN - 1);

  // offset-binary core code to two's complement: invert the sign bit
  function automatic sadc_word_t to_twos(input sadc_word_t code);
    to_twos = code ^ `SADC_SIGN_FLIP;
  endfunction

  // sample buffer between the core's sample stream and the converter
  sadc_stream_if wr_if ();
  sadc_stream_if rd_if ();

  assign wr_if.data = i_sample_data;
  assign wr_if.valid = i_sample_valid;

  sadc_fifo #(
    .WIDTH(`SADC_WORD_W),
    .DEPTH(`SADC_FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .s_in(wr_if.snk),
    .s_out(rd_if.src)
  );

  // pin synchronisers: bit 0 strobe, bit 1 mode, bit 2 shared pin
  logic [2:0] pin_s1_reg, pin_s1_next, pin_s2_reg, pin_s2_next;
  logic strobe_prev_reg, strobe_prev_next;
  logic strobe_sync, chain_sync, read_output_enable_n_sync;
  logic conv_rise;

  always_comb
  begin
    pin_s1_next = {i_enable_or_serial_in, i_chain_select, i_convert_strobe};
    pin_s2_next = pin_s1_reg;
    strobe_prev_next = pin_s2_reg[0];
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      // idle-high enable so the output is not driven right after reset
      pin_s1_reg <= `SADC_PIN_IDLE;
      pin_s2_reg <= `SADC_PIN_IDLE;
      strobe_prev_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
      strobe_prev_reg <= strobe_prev_next;
    end
  end

  assign strobe_sync = pin_s2_reg[0];
  assign chain_sync = pin_s2_reg[1];
  assign read_output_enable_n_sync = pin_s2_reg[2];
  assign conv_rise = strobe_sync && !strobe_prev_reg; // R1

  // conversion sequencer; a strobe edge during busy is ignored
  sadc_state_t state_reg, state_next;
  sadc_cnt_t cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic power_reg, power_next;
  sadc_word_t sample_reg, sample_next;
  sadc_word_t word_reg, word_next;
  logic oe_reg, oe_next;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    power_next = power_reg;
    sample_next = sample_reg;
    word_next = word_reg;
    rd_if.ready = 1'b0;
    case (state_reg)
      SADC_IDLE:
      begin
        if (conv_rise)
        begin
          state_next = SADC_CONV; // R1
          cnt_next = '0;
          busy_next = 1'b1; // R2
          power_next = 1'b1; // R1
          rd_if.ready = 1'b1;
          // an empty buffer converts as bipolar zero
          sample_next = rd_if.valid ? rd_if.data : `SADC_MID_CODE;
        end
      end
      SADC_CONV:
      begin
        cnt_next = cnt_reg + sadc_cnt_t'(1);
        if (cnt_reg == ConvLast)
        begin
          state_next = SADC_IDLE;
          busy_next = 1'b0; // R2
          power_next = 1'b0;
          word_next = to_twos(sample_reg); // R9 R14
        end
      end
      default:
      begin
        state_next = SADC_IDLE;
        busy_next = 1'b0;
        power_next = 1'b0;
      end
    endcase
    // chain mode keeps the output driven; normal mode follows the pin
    oe_next = chain_sync ? 1'b1 : !read_output_enable_n_sync; // R5 R6 R7
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_reg <= SADC_IDLE;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      power_reg <= 1'b0;
      sample_reg <= '0;
      word_reg <= '0;
      oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      power_reg <= power_next;
      sample_reg <= sample_next;
      word_reg <= word_next;
      oe_reg <= oe_next;
    end
  end

  // link side: word_reg only changes while busy holds this logic clear,
  // so it is stable whenever the shift clock may run
  logic sck_arst_n;
  logic chain_s1_reg, chain_s1_next, chain_s2_reg, chain_s2_next;
  logic started_reg, started_next;
  sadc_word_t shift_reg, shift_next;
  logic shift_in;

  assign sck_arst_n = i_arst_n && !busy_reg;

  always_comb
  begin
    chain_s1_next = i_chain_select;
    chain_s2_next = chain_s1_reg;
    // upstream data arrives on the link's own clock, no sync needed
    shift_in = chain_s2_reg ? i_enable_or_serial_in : 1'b0; // R11
    started_next = 1'b1;
    if (started_reg)
      shift_next = {shift_reg[`SADC_MSB-1:0], shift_in}; // R8 R15
    else
      shift_next = {word_reg[`SADC_MSB-1:0], shift_in}; // R14 R15
  end

  // busy clears the frame so every readout starts at the MSB
  always_ff @(posedge i_sck or negedge sck_arst_n)
  begin
    if (!sck_arst_n)
    begin
      started_reg <= 1'b0;
      shift_reg <= '0;
    end
    else
    begin
      started_reg <= started_next;
      shift_reg <= shift_next;
    end
  end

  // mode pin caught on the link clock too; clear only at reset
  always_ff @(posedge i_sck or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      chain_s1_reg <= 1'b0;
      chain_s2_reg <= 1'b0;
    end
    else
    begin
      chain_s1_reg <= chain_s1_next;
      chain_s2_reg <= chain_s2_next;
    end
  end

  // outputs; the first bit needs no shift edge, so data picks the held
  // word until the first edge (a select of two flops, not a gate tree)
  assign o_sample_ready = wr_if.ready;
  assign o_busy = busy_reg; // R2
  assign o_powered_up = power_reg;
  assign o_sdo = started_reg ? shift_reg[`SADC_MSB] : word_reg[`SADC_MSB]; // R10
  assign o_sdo_oe = oe_reg; // R7

  // checks on the system clock
  a_start_raises_busy : assert property ( // R1
    @(posedge i_clock) disable iff (!i_arst_n)
    (conv_rise && state_reg == SADC_IDLE) |=> (busy_reg && power_reg))
    else $error("busy did not rise after a convert edge");

  a_power_tracks_busy : assert property ( // R1
    @(posedge i_clock) disable iff (!i_arst_n)
    power_reg == busy_reg)
    else $error("core power does not follow busy");

  a_busy_length : assert property ( // R2
    @(posedge i_clock) disable iff (!i_arst_n)
    $rose(busy_reg) |-> (busy_reg throughout ##ConvHold 1'b1) ##1 !busy_reg)
    else $error("busy width differs from the conversion time");

  a_busy_bounded : assert property ( // R2
    @(posedge i_clock) disable iff (!i_arst_n)
    $rose(busy_reg) |-> ##[ConvMin:ConvMax] !busy_reg)
    else $error("conversion outside its time window");

  a_oe_normal : assert property ( // R5 R7
    @(posedge i_clock) disable iff (!i_arst_n)
    (!chain_sync && $fell(read_output_enable_n_sync)) |=> o_sdo_oe
      ##1 o_sdo_oe || read_output_enable_n_sync)
    else $error("output not driven after enable fell");

  a_oe_release : assert property ( // R7
    @(posedge i_clock) disable iff (!i_arst_n)
    (!chain_sync && read_output_enable_n_sync) |=> !o_sdo_oe)
    else $error("output not released after enable rose");

  a_oe_chain : assert property ( // R6
    @(posedge i_clock) disable iff (!i_arst_n)
    chain_sync |=> o_sdo_oe)
    else $error("chain mode must keep the output driven");

  a_result_code : assert property ( // R9 R14
    @(posedge i_clock) disable iff (!i_arst_n)
    $fell(busy_reg) |-> (word_reg == ($past(sample_reg) ^ 16'h8000)))
    else $error("result is not the fresh two's complement word");

  a_first_bit : assert property ( // R10
    @(posedge i_clock) disable iff (!i_arst_n)
    $fell(busy_reg) |-> (o_sdo == word_reg[`SADC_MSB]))
    else $error("first result bit missing as busy fell");

  // checks on the link clock
  a_shift_msb : assert property ( // R8
    @(posedge i_sck) disable iff (!sck_arst_n)
    !started_reg |=> (o_sdo == $past(word_reg[`SADC_MSB-1])))
    else $error("second bit is not the next result bit");

  a_chain_shift : assert property ( // R11 R15
    @(posedge i_sck) disable iff (!sck_arst_n)
    (started_reg && chain_s2_reg) |=>
      (shift_reg == {$past(shift_reg[`SADC_MSB-1:0]),
                     $past(i_enable_or_serial_in)}))
    else $error("chain data not shifted in at the low end");
endmodule // sadc_top

`default_nettype wire
